// *** rtl/lrdp_pkg.sv ***
package lrdp_pkg;

  localparam int BYTE_W = 8;
  localparam int MAC_W  = 24;
  localparam int PFX_W  = 5;
  localparam int SYN_W  = 5;
  localparam int CNT_W  = 4;
  localparam int IDX_W  = 3;

  // Descriptor type tags; the real values are assigned outside this block
  localparam logic [7:0] TAG_LOGON_RESP_DEF = 8'h01;
  localparam logic [7:0] TAG_DHCP_OPT_DEF   = 8'h02;

  // Body byte indices where each section ends
  localparam logic [IDX_W-1:0] LR_HDR_LAST   = 3'h7;
  localparam logic [IDX_W-1:0] LR_ENT_LAST   = 3'h4;
  localparam logic [IDX_W-1:0] LR_TAIL_LAST  = 3'h2;
  localparam logic [IDX_W-1:0] DHCP_HDR_LAST = 3'h3;

  // Logon response header, entry and tail byte indices, then option header byte indices
  localparam logic [IDX_W-1:0] LR_IX_FLAGS   = 3'h0;
  localparam logic [IDX_W-1:0] LR_IX_GROUP   = 3'h1;
  localparam logic [IDX_W-1:0] LR_IX_SESS_HI = 3'h2;
  localparam logic [IDX_W-1:0] LR_IX_SESS_LO = 3'h3;
  localparam logic [IDX_W-1:0] LR_IX_BASE_2  = 3'h4;
  localparam logic [IDX_W-1:0] LR_IX_BASE_1  = 3'h5;
  localparam logic [IDX_W-1:0] LR_IX_BASE_0  = 3'h6;
  localparam logic [IDX_W-1:0] LR_IX_MAC_1   = 3'h2;
  localparam logic [IDX_W-1:0] LR_IX_MAC_2   = 3'h3;
  localparam logic [IDX_W-1:0] LR_IX_SVN_HI  = 3'h0;
  localparam logic [IDX_W-1:0] LR_IX_SVN_LO  = 3'h1;
  localparam logic [IDX_W-1:0] DH_IX_IF_1    = 3'h1;
  localparam logic [IDX_W-1:0] DH_IX_IF_0    = 3'h2;

  // Bit positions inside the flag byte, the last header byte and entry bytes
  localparam int KEEP_BIT   = 6;
  localparam int PCM_HI     = 5;
  localparam int PCM_LO     = 4;
  localparam int STAT_HI    = 3;
  localparam int NIB_HI     = 7;
  localparam int NIB_LO     = 4;
  localparam int METHOD_BIT = 6;
  localparam int IPVER_BIT  = 5;

  localparam logic [1:0] PCM_CONST_POWER = 2'h0;
  localparam logic [1:0] PCM_AUTONOMOUS  = 2'h1;
  localparam logic [1:0] PCM_CONST_PSD   = 2'h2;
  localparam logic [1:0] PCM_RESERVED    = 2'h3;

  localparam logic [MAC_W-1:0] IFACE_ALL = 24'hff_ffff;
  localparam logic [7:0] DHCP_HDR_LEN    = 8'h04;

  localparam logic [7:0] OPT_DNS      = 8'h06;
  localparam logic [7:0] OPT_HOSTNAME = 8'h0c;
  localparam logic [7:0] OPT_MTU      = 8'h1a;
  localparam logic [7:0] OPT_VENDOR   = 8'h2b;
  localparam logic [7:0] OPT_LIST     = 8'h37;
  localparam logic [7:0] OPT_RSV_LO   = 8'h80;
  localparam logic [7:0] OPT_RSV_HI   = 8'h96;

  // Output record: {is_option, last, opt_byte, prefix, mac, vnet, table, ipver, synth}
  localparam int REC_W = 2 + BYTE_W + PFX_W + 2 * MAC_W + 2 + SYN_W;
  localparam int BUF_DEPTH = 2;

  typedef enum logic [2:0] {
    S_TAG, S_LEN, S_LR_HDR, S_LR_ENT, S_LR_TAIL, S_DHCP_HDR, S_DHCP_DATA, S_SKIP
  } lrdp_state_t;

endpackage

// *** rtl/lrdp_fifo.sv ***
`timescale 1ns/1ns
module lrdp_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  input  wire logic         ref_clk_in,
  input  wire logic         arst_n_in,
  input  wire logic         ce_in,
  input  wire logic         in_valid_in,
  input  wire logic [W-1:0] in_data_in,
  output logic              in_ready_out,
  output logic              out_valid_out,
  output logic [W-1:0]      out_data_out,
  input  wire logic         out_ready_in
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0]   FULL_CNT = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_PTR = AW'(DEPTH - 1);

  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0]   count_r;
  logic          push;
  logic          pop;

  assign in_ready_out  = count_r != FULL_CNT;
  assign out_valid_out = count_r != '0;
  assign out_data_out  = mem_r[rd_ptr_r];
  assign push = ce_in && in_valid_in && in_ready_out;
  assign pop  = ce_in && out_valid_out && out_ready_in;

  always_ff @(posedge ref_clk_in) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data_in;
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= (wr_ptr_r == LAST_PTR) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop) begin
        rd_ptr_r <= (rd_ptr_r == LAST_PTR) ? '0 : rd_ptr_r + 1'b1;
      end
      if (push && !pop) begin
        count_r <= count_r + 1'b1;
      end else if (pop && !push) begin
        count_r <= count_r - 1'b1;
      end
    end
  end
endmodule

// *** rtl/lrdp_vnet_extract.sv ***
`timescale 1ns/1ns
module lrdp_vnet_extract #(
  parameter int MAC_W = 24,
  parameter int PFX_W = 5
) (
  input  wire logic [MAC_W-1:0] mac_in,
  input  wire logic [PFX_W-1:0] prefix_in,
  output logic      [MAC_W-1:0] vnet_out
);
  localparam logic [PFX_W:0] MAC_WIDTH = (PFX_W + 1)'(MAC_W);

  logic [PFX_W:0]   pfx_c;
  logic [PFX_W:0]   shamt;
  logic [MAC_W-1:0] shifted;

  // A prefix wider than the address takes the whole address
  assign pfx_c   = ({1'b0, prefix_in} > MAC_WIDTH) ? MAC_WIDTH : {1'b0, prefix_in};
  assign shamt   = MAC_WIDTH - pfx_c;
  assign shifted = mac_in >> shamt;

  for (genvar i = 0; i < MAC_W; i++) begin : g_mask
    assign vnet_out[i] = shifted[i] && ((PFX_W + 1)'(i) < pfx_c);
  end
endmodule

// *** rtl/lrdp_parser.sv ***
`timescale 1ns/1ns
module lrdp_parser #(
  parameter logic [7:0] TAG_LOGON_RESP = lrdp_pkg::TAG_LOGON_RESP_DEF,
  parameter logic [7:0] TAG_DHCP_OPT   = lrdp_pkg::TAG_DHCP_OPT_DEF
) (
  input  wire logic                       ref_clk_in,
  input  wire logic                       arst_n_in,
  input  wire logic                       ce_in,
  input  wire logic                       msg_bcast_in,
  input  wire logic                       byte_valid_in,
  input  wire logic [lrdp_pkg::BYTE_W-1:0] byte_data_in,
  output logic                            byte_ready_out,
  output logic                            keep_ids_out,
  output logic                            discard_ids_out,
  output logic [1:0]                      pcm_out,
  output logic                            pcm_const_power_out,
  output logic                            pcm_autonomous_out,
  output logic                            pcm_const_psd_out,
  output logic [lrdp_pkg::CNT_W-1:0]      access_state_out,
  output logic [7:0]                      assigned_group_out,
  output logic [15:0]                     assigned_session_out,
  output logic [lrdp_pkg::MAC_W-1:0]      base_alloc_ident_out,
  output logic [lrdp_pkg::CNT_W-1:0]      alloc_ident_count_out,
  output logic [lrdp_pkg::CNT_W-1:0]      mac_count_out,
  output logic [15:0]                     default_vnet_out,
  output logic                            logon_done_out,
  output logic [lrdp_pkg::MAC_W-1:0]      dhcp_iface_out,
  output logic                            dhcp_iface_all_out,
  output logic [7:0]                      dhcp_code_out,
  output logic [7:0]                      dhcp_opt_len_out,
  output logic                            dhcp_code_known_out,
  output logic                            dhcp_code_reserved_out,
  output logic                            dhcp_hdr_out,
  output logic                            rec_valid_out,
  input  wire logic                       rec_ready_in,
  output logic                            rec_is_option_out,
  output logic                            rec_last_out,
  output logic [lrdp_pkg::BYTE_W-1:0]     opt_byte_out,
  output logic [lrdp_pkg::PFX_W-1:0]      ent_prefix_out,
  output logic [lrdp_pkg::MAC_W-1:0]      ent_mac_out,
  output logic [lrdp_pkg::MAC_W-1:0]      ent_vnet_out,
  output logic                            ent_table_map_out,
  output logic                            ent_ipver_present_out,
  output logic [lrdp_pkg::SYN_W-1:0]      ent_synth_size_out,
  output logic                            error_out
);
  lrdp_pkg::lrdp_state_t state_r;
  lrdp_pkg::lrdp_state_t state_nxt;

  logic [7:0]                    tag_r;
  logic [7:0]                    len_r;
  logic [7:0]                    rem_r;
  logic [lrdp_pkg::IDX_W-1:0]    idx_r;
  logic [lrdp_pkg::CNT_W-1:0]    ents_left_r;
  logic [lrdp_pkg::PFX_W-1:0]    ent_prefix_r;
  logic [lrdp_pkg::MAC_W-1:0]    ent_mac_r;
  logic [lrdp_pkg::MAC_W-1:0]    vnet;
  logic [lrdp_pkg::REC_W-1:0]    rec_in;
  logic [lrdp_pkg::REC_W-1:0]    rec_out;
  logic                          buf_ready;
  logic                          take;
  logic                          last;
  logic                          push;
  logic                          err_nxt;
  logic                          lr_end;
  logic                          table_map;

  // Known codes depend on which message kind carries the option
  function automatic logic code_known(input logic [7:0] code, input logic bcast);
    code_known = (code == lrdp_pkg::OPT_DNS) || (code == lrdp_pkg::OPT_MTU) ||
                 (code == lrdp_pkg::OPT_VENDOR) ||
                 (!bcast && code == lrdp_pkg::OPT_HOSTNAME) ||
                 (bcast && code == lrdp_pkg::OPT_LIST);
  endfunction

  // Stall the whole stream while the record buffer is full; simple, never drops a record
  assign byte_ready_out = ce_in && buf_ready;
  assign take = byte_valid_in && byte_ready_out;
  assign last = rem_r == 8'h01;
  assign table_map = byte_data_in[lrdp_pkg::METHOD_BIT];
  assign push = take && ((state_r == lrdp_pkg::S_LR_ENT && idx_r == lrdp_pkg::LR_ENT_LAST) ||
                         state_r == lrdp_pkg::S_DHCP_DATA);

  always_comb begin
    state_nxt = state_r;
    err_nxt   = 1'b0;
    lr_end    = 1'b0;
    if (take) begin
      unique case (state_r)
        lrdp_pkg::S_TAG: begin
          state_nxt = lrdp_pkg::S_LEN;
        end
        lrdp_pkg::S_LEN: begin
          if (byte_data_in == 8'h00) begin
            state_nxt = lrdp_pkg::S_TAG;
            err_nxt   = (tag_r == TAG_LOGON_RESP) || (tag_r == TAG_DHCP_OPT);
          end else if (tag_r == TAG_LOGON_RESP) begin
            state_nxt = lrdp_pkg::S_LR_HDR;
          end else if (tag_r == TAG_DHCP_OPT) begin
            state_nxt = lrdp_pkg::S_DHCP_HDR;
          end else begin
            state_nxt = lrdp_pkg::S_SKIP;
          end
        end
        lrdp_pkg::S_LR_HDR: begin
          err_nxt = idx_r == lrdp_pkg::LR_IX_FLAGS &&
                    byte_data_in[lrdp_pkg::PCM_HI:lrdp_pkg::PCM_LO] ==
                    lrdp_pkg::PCM_RESERVED;
          if (last) begin
            state_nxt = lrdp_pkg::S_TAG;
            err_nxt   = 1'b1;
          end else if (idx_r == lrdp_pkg::LR_HDR_LAST) begin
            state_nxt = (byte_data_in[lrdp_pkg::STAT_HI:0] == '0) ?
                        lrdp_pkg::S_LR_TAIL : lrdp_pkg::S_LR_ENT;
          end
        end
        lrdp_pkg::S_LR_ENT: begin
          if (last) begin
            state_nxt = lrdp_pkg::S_TAG;
            err_nxt   = 1'b1;
          end else if (idx_r == lrdp_pkg::LR_ENT_LAST && ents_left_r == 4'h1) begin
            state_nxt = lrdp_pkg::S_LR_TAIL;
          end
        end
        lrdp_pkg::S_LR_TAIL: begin
          if (idx_r == lrdp_pkg::LR_TAIL_LAST) begin
            lr_end    = 1'b1;
            state_nxt = last ? lrdp_pkg::S_TAG : lrdp_pkg::S_SKIP;
            err_nxt   = !last;
          end else if (last) begin
            state_nxt = lrdp_pkg::S_TAG;
            err_nxt   = 1'b1;
          end
        end
        lrdp_pkg::S_DHCP_HDR: begin
          if (idx_r == lrdp_pkg::DHCP_HDR_LAST) begin
            state_nxt = last ? lrdp_pkg::S_TAG : lrdp_pkg::S_DHCP_DATA;
          end else if (last) begin
            state_nxt = lrdp_pkg::S_TAG;
            err_nxt   = 1'b1;
          end
        end
        lrdp_pkg::S_DHCP_DATA, lrdp_pkg::S_SKIP: begin
          if (last) begin
            state_nxt = lrdp_pkg::S_TAG;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state_r <= lrdp_pkg::S_TAG;
      tag_r   <= '0;
      len_r   <= '0;
      rem_r   <= '0;
      idx_r   <= '0;
    end else if (take) begin
      state_r <= state_nxt;
      if (state_r == lrdp_pkg::S_TAG) begin
        tag_r <= byte_data_in;
      end
      if (state_r == lrdp_pkg::S_LEN) begin
        len_r <= byte_data_in;
        rem_r <= byte_data_in;
      end else if (state_r != lrdp_pkg::S_TAG) begin
        rem_r <= rem_r - 8'h01;
      end
      if (state_nxt != state_r ||
          (state_r == lrdp_pkg::S_LR_ENT && idx_r == lrdp_pkg::LR_ENT_LAST)) begin
        idx_r <= '0;
      end else begin
        idx_r <= idx_r + 1'b1;
      end
    end
  end

  // Logon response header and tail fields
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      keep_ids_out          <= 1'b0;
      pcm_out               <= lrdp_pkg::PCM_CONST_POWER;
      access_state_out      <= '0;
      assigned_group_out    <= '0;
      assigned_session_out  <= '0;
      base_alloc_ident_out  <= '0;
      alloc_ident_count_out <= '0;
      mac_count_out         <= '0;
      default_vnet_out      <= '0;
    end else if (take && state_r == lrdp_pkg::S_LR_HDR) begin
      unique case (idx_r)
        lrdp_pkg::LR_IX_FLAGS: begin
          keep_ids_out     <= byte_data_in[lrdp_pkg::KEEP_BIT];
          pcm_out          <= byte_data_in[lrdp_pkg::PCM_HI:lrdp_pkg::PCM_LO];
          access_state_out <= byte_data_in[lrdp_pkg::STAT_HI:0];
        end
        lrdp_pkg::LR_IX_GROUP:   assigned_group_out <= byte_data_in;
        lrdp_pkg::LR_IX_SESS_HI: assigned_session_out[15:8] <= byte_data_in;
        lrdp_pkg::LR_IX_SESS_LO: assigned_session_out[7:0] <= byte_data_in;
        lrdp_pkg::LR_IX_BASE_2:  base_alloc_ident_out[23:16] <= byte_data_in;
        lrdp_pkg::LR_IX_BASE_1:  base_alloc_ident_out[15:8] <= byte_data_in;
        lrdp_pkg::LR_IX_BASE_0:  base_alloc_ident_out[7:0] <= byte_data_in;
        lrdp_pkg::LR_HDR_LAST: begin
          alloc_ident_count_out <= byte_data_in[lrdp_pkg::NIB_HI:lrdp_pkg::NIB_LO];
          mac_count_out         <= byte_data_in[lrdp_pkg::STAT_HI:0];
        end
      endcase
    end else if (take && state_r == lrdp_pkg::S_LR_TAIL) begin
      if (idx_r == lrdp_pkg::LR_IX_SVN_HI) begin
        default_vnet_out[15:8] <= byte_data_in;
      end else if (idx_r == lrdp_pkg::LR_IX_SVN_LO) begin
        default_vnet_out[7:0] <= byte_data_in;
      end
    end
  end

  assign discard_ids_out     = !keep_ids_out;
  assign pcm_const_power_out = pcm_out == lrdp_pkg::PCM_CONST_POWER;
  assign pcm_autonomous_out  = pcm_out == lrdp_pkg::PCM_AUTONOMOUS;
  assign pcm_const_psd_out   = pcm_out == lrdp_pkg::PCM_CONST_PSD;

  // Address entry collection
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ents_left_r  <= '0;
      ent_prefix_r <= '0;
      ent_mac_r    <= '0;
    end else if (take) begin
      if (state_r == lrdp_pkg::S_LR_HDR && idx_r == lrdp_pkg::LR_HDR_LAST) begin
        ents_left_r <= byte_data_in[lrdp_pkg::STAT_HI:0];
      end
      if (state_r == lrdp_pkg::S_LR_ENT) begin
        unique case (idx_r)
          3'h0: ent_prefix_r <= byte_data_in[lrdp_pkg::PFX_W-1:0];
          3'h1: ent_mac_r[23:16] <= byte_data_in;
          lrdp_pkg::LR_IX_MAC_1: ent_mac_r[15:8] <= byte_data_in;
          lrdp_pkg::LR_IX_MAC_2: ent_mac_r[7:0] <= byte_data_in;
          default: ents_left_r <= ents_left_r - 1'b1;
        endcase
      end
    end
  end

  lrdp_vnet_extract #(
    .MAC_W (lrdp_pkg::MAC_W),
    .PFX_W (lrdp_pkg::PFX_W)
  ) u_vnet (
    .mac_in    (ent_mac_r),
    .prefix_in (ent_prefix_r),
    .vnet_out  (vnet)
  );

  // Under table mapping the version and synthesis fields are forced to zero
  assign rec_in = {state_r == lrdp_pkg::S_DHCP_DATA,
                   last,
                   byte_data_in,
                   ent_prefix_r,
                   ent_mac_r,
                   vnet,
                   table_map,
                   !table_map && byte_data_in[lrdp_pkg::IPVER_BIT],
                   table_map ? 5'h00 : byte_data_in[lrdp_pkg::SYN_W-1:0]};

  lrdp_fifo #(
    .W     (lrdp_pkg::REC_W),
    .DEPTH (lrdp_pkg::BUF_DEPTH)
  ) u_buf (
    .ref_clk_in    (ref_clk_in),
    .arst_n_in     (arst_n_in),
    .ce_in         (ce_in),
    .in_valid_in   (push),
    .in_data_in    (rec_in),
    .in_ready_out  (buf_ready),
    .out_valid_out (rec_valid_out),
    .out_data_out  (rec_out),
    .out_ready_in  (rec_ready_in)
  );

  assign {rec_is_option_out, rec_last_out, opt_byte_out, ent_prefix_out, ent_mac_out,
          ent_vnet_out, ent_table_map_out, ent_ipver_present_out, ent_synth_size_out} = rec_out;

  // Option descriptor header
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      dhcp_iface_out         <= '0;
      dhcp_iface_all_out     <= 1'b0;
      dhcp_code_out          <= '0;
      dhcp_opt_len_out       <= '0;
      dhcp_code_known_out    <= 1'b0;
      dhcp_code_reserved_out <= 1'b0;
    end else if (take && state_r == lrdp_pkg::S_DHCP_HDR) begin
      unique case (idx_r)
        3'h0:                 dhcp_iface_out[23:16] <= byte_data_in;
        lrdp_pkg::DH_IX_IF_1: dhcp_iface_out[15:8] <= byte_data_in;
        lrdp_pkg::DH_IX_IF_0: begin
          dhcp_iface_out[7:0] <= byte_data_in;
          dhcp_iface_all_out  <= {dhcp_iface_out[23:8], byte_data_in} ==
                                 lrdp_pkg::IFACE_ALL;
        end
        default: begin
          dhcp_code_out          <= byte_data_in;
          dhcp_opt_len_out       <= len_r - lrdp_pkg::DHCP_HDR_LEN;
          dhcp_code_known_out    <= code_known(byte_data_in, msg_bcast_in);
          dhcp_code_reserved_out <= byte_data_in >= lrdp_pkg::OPT_RSV_LO &&
                                    byte_data_in <= lrdp_pkg::OPT_RSV_HI;
        end
      endcase
    end
  end

  // Event pulses
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      logon_done_out <= 1'b0;
      dhcp_hdr_out   <= 1'b0;
      error_out      <= 1'b0;
    end else if (ce_in) begin
      logon_done_out <= lr_end && last;
      dhcp_hdr_out   <= take && state_r == lrdp_pkg::S_DHCP_HDR &&
                        idx_r == lrdp_pkg::DHCP_HDR_LAST;
      error_out      <= err_nxt;
    end
  end
endmodule

// *** test/lrdp_props.sv ***
`timescale 1ns/1ns
module lrdp_props (
  input wire logic        ref_clk_in,
  input wire logic        arst_n_in,
  input wire logic        ce_in,
  input wire logic        byte_ready_out,
  input wire logic        keep_ids_out,
  input wire logic        discard_ids_out,
  input wire logic [1:0]  pcm_out,
  input wire logic        pcm_const_power_out,
  input wire logic        pcm_autonomous_out,
  input wire logic        pcm_const_psd_out,
  input wire logic [23:0] dhcp_iface_out,
  input wire logic        dhcp_iface_all_out,
  input wire logic [7:0]  dhcp_code_out,
  input wire logic        dhcp_code_reserved_out,
  input wire logic        dhcp_hdr_out,
  input wire logic        rec_valid_out,
  input wire logic        rec_ready_in,
  input wire logic        rec_is_option_out,
  input wire logic [7:0]  opt_byte_out,
  input wire logic [4:0]  ent_prefix_out,
  input wire logic [23:0] ent_mac_out,
  input wire logic [23:0] ent_vnet_out,
  input wire logic        ent_table_map_out,
  input wire logic        ent_ipver_present_out,
  input wire logic [4:0]  ent_synth_size_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  property p_disc; discard_ids_out == !keep_ids_out; endproperty
  a_disc: assert property (p_disc) else $error("discard flag wrong");
  property p_pwr; pcm_const_power_out == (pcm_out == 2'h0); endproperty
  a_pwr: assert property (p_pwr) else $error("power decode wrong");
  property p_auto; {pcm_autonomous_out, pcm_const_psd_out} == {pcm_out == 2'h1, pcm_out == 2'h2};
  endproperty
  a_auto: assert property (p_auto) else $error("mode decode wrong");
  property p_all; dhcp_hdr_out |-> dhcp_iface_all_out == &dhcp_iface_out; endproperty
  a_all: assert property (p_all) else $error("all-interface flag wrong");
  property p_rsv; dhcp_hdr_out |-> dhcp_code_reserved_out == (dhcp_code_out inside {[8'h80:8'h96]});
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved code flag wrong");
  property p_tbl; rec_valid_out && !rec_is_option_out && ent_table_map_out
    |-> !ent_ipver_present_out && ent_synth_size_out == 5'h00; endproperty
  a_tbl: assert property (p_tbl) else $error("table entry fields not cleared");
  property p_vnet; rec_valid_out && !rec_is_option_out |-> ent_vnet_out ==
    (ent_prefix_out > 5'h17 ? ent_mac_out : ent_mac_out >> (5'h18 - ent_prefix_out)); endproperty
  a_vnet: assert property (p_vnet) else $error("network number wrong");
  // A stalled record must not change under the sink
  property p_hold; rec_valid_out && !rec_ready_in
    |=> rec_valid_out && $stable(opt_byte_out) && $stable(ent_mac_out); endproperty
  a_hold: assert property (p_hold) else $error("record changed while stalled");
  property p_ce; !ce_in |-> !byte_ready_out; endproperty
  a_ce: assert property (p_ce) else $error("ready while disabled");
  c_stall: cover property (rec_valid_out && !byte_ready_out && ce_in);
  c_all: cover property (dhcp_hdr_out && dhcp_iface_all_out);
  c_rsvd: cover property (pcm_out == 2'h3);
endmodule
bind lrdp_parser lrdp_props lrdp_props_inst (.*);

// *** test/lrdp_src.sv ***
`timescale 1ns/1ns
module lrdp_src (
  input  wire logic       ref_clk_in,
  input  wire logic       arst_n_in,
  input  wire logic       ready_in,
  input  wire logic [3:0] gap_in,
  output logic            valid_out = 1'b0,
  output logic [7:0]      data_out = 8'h00
);
  logic [7:0] q[$];
  logic [3:0] wait_r;
  // Byte held until taken; idle data toggles so a stale byte never looks fresh
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      valid_out <= 1'b0;
      wait_r    <= 4'h0;
    end else if (!valid_out || ready_in) begin
      valid_out <= !(wait_r < gap_in || q.size() == 0);
      wait_r    <= (wait_r < gap_in || q.size() == 0) ? wait_r + 4'h1 : 4'h0;
      data_out  <= (wait_r < gap_in || q.size() == 0) ? ~data_out : q.pop_front();
    end
  end
endmodule

// *** test/lrdp_parser_tb_top.sv ***
`timescale 1ns/1ns
module lrdp_parser_tb_top;
  logic        ref_clk_in, arst_n_in, ce_in, msg_bcast_in, rec_ready_in, byte_valid_in;
  logic        byte_ready_out, keep_ids_out, discard_ids_out, pcm_const_power_out, error_out;
  logic        pcm_autonomous_out, pcm_const_psd_out, logon_done_out, dhcp_iface_all_out;
  logic        dhcp_code_known_out, dhcp_code_reserved_out, dhcp_hdr_out, rec_valid_out;
  logic        rec_is_option_out, rec_last_out, ent_table_map_out, ent_ipver_present_out;
  logic [1:0]  pcm_out;
  logic [3:0]  access_state_out, alloc_ident_count_out, mac_count_out, gap;
  logic [4:0]  ent_prefix_out, ent_synth_size_out;
  logic [7:0]  byte_data_in, assigned_group_out, dhcp_code_out, dhcp_opt_len_out, opt_byte_out;
  logic [15:0] assigned_session_out, default_vnet_out;
  logic [23:0] base_alloc_ident_out, dhcp_iface_out, ent_mac_out, ent_vnet_out;
  logic [8:0]  rq[$];
  int          fail_count, comparisons, err_n, done_n, hdr_n;
  logic [7:0]  no_bytes[];
  lrdp_parser lrdp_parser_inst (.*);
  lrdp_src lrdp_src_inst (.ref_clk_in(ref_clk_in), .arst_n_in(arst_n_in),
    .ready_in(byte_ready_out), .gap_in(gap), .valid_out(byte_valid_in), .data_out(byte_data_in));
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  initial begin
    #100000 fail_count++;
    wrap_up();
  end
  always @(posedge ref_clk_in) begin
    if (error_out) err_n++;
    if (logon_done_out) done_n++;
    if (dhcp_hdr_out) hdr_n++;
    if (rec_valid_out && rec_ready_in && rec_is_option_out) rq.push_back({rec_last_out, opt_byte_out});
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  task automatic send(input logic [7:0] b[], input bit wait_idle);
    foreach (b[k]) lrdp_src_inst.q.push_back(b[k]);
    for (int i = 0; i < 300 && wait_idle && (lrdp_src_inst.q.size() > 0 || byte_valid_in); i++)
      @(negedge ref_clk_in);
    repeat (4) @(negedge ref_clk_in);
  endtask
  task automatic t_logon(); // One entry, sink stalled so the record waits at the output
    rec_ready_in <= 1'b0;
    send('{8'h01, 8'h10, 8'h6a, 8'h5c, 8'h12, 8'h34, 8'hab, 8'hcd, 8'hef, 8'h31,
      8'h08, 8'hc3, 8'h21, 8'h07, 8'h37, 8'h0f, 8'hed, 8'h00}, 1'b1);
    chk(done_n, 48'h1);
    chk({keep_ids_out, discard_ids_out, pcm_out, pcm_const_psd_out, access_state_out}, 9'h15a);
    chk({assigned_group_out, assigned_session_out}, 24'h5c_1234);
    chk({base_alloc_ident_out, alloc_ident_count_out, mac_count_out}, 32'habcd_ef31);
    chk(default_vnet_out, 16'h0fed);
    chk({rec_valid_out, rec_is_option_out, ent_prefix_out, ent_mac_out}, {2'h2, 5'h08, 24'hc3_2107});
    chk({ent_vnet_out, ent_table_map_out, ent_ipver_present_out, ent_synth_size_out}, {24'h00_00c3, 7'h37});
  endtask
  task automatic t_reserved(); // Reserved mode, table entry, then a short length
    int d0;
    @(posedge ref_clk_in);
    rec_ready_in <= 1'b1;
    send('{8'h01, 8'h10, 8'h3f, 8'h01, 8'h00, 8'h02, 8'h00, 8'h00, 8'h10, 8'hf1,
      8'h1f, 8'h80, 8'h00, 8'h01, 8'h7f, 8'h00, 8'h01, 8'h00}, 1'b1);
    chk({err_n[3:0], discard_ids_out, pcm_out, pcm_const_power_out, pcm_autonomous_out, pcm_const_psd_out}, {4'h1, 6'h38});
    d0 = done_n;
    send('{8'h01, 8'h0a, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00}, 1'b1);
    chk({err_n[3:0], 4'(done_n - d0)}, 8'h20);
  endtask
  task automatic t_dhcp(); // Two options back to back into a stalled sink
    @(posedge ref_clk_in);
    rec_ready_in <= 1'b0;
    msg_bcast_in <= 1'b1;
    rq.delete();
    send('{8'h02, 8'h06, 8'hff, 8'hff, 8'hff, 8'h37, 8'haa, 8'hbb,
      8'h02, 8'h05, 8'hff, 8'hff, 8'hff, 8'h0c, 8'h55}, 1'b0);
    for (int i = 0; i < 50 && byte_ready_out; i++) @(negedge ref_clk_in);
    chk({byte_ready_out, rec_valid_out, opt_byte_out, rec_last_out}, {2'h1, 8'haa, 1'b0});
    @(posedge ref_clk_in);
    rec_ready_in <= 1'b1;
    send(no_bytes, 1'b1);
    chk({rq[0], rq[1], rq[2]}, {9'h0aa, 9'h1bb, 9'h155});
    chk({dhcp_iface_all_out, dhcp_code_out, dhcp_opt_len_out, dhcp_code_known_out}, {1'b1, 8'h0c, 8'h01, 1'b0});
  endtask
  task automatic t_skip(); // Unknown tag whose body mimics an option header, slow source
    gap = 4'h2;
    @(posedge ref_clk_in);
    msg_bcast_in <= 1'b0;
    rq.delete();
    send('{8'h77, 8'h03, 8'h02, 8'h04, 8'h01, 8'h02, 8'h05, 8'h01, 8'h02, 8'h03, 8'h0c, 8'h99}, 1'b1);
    chk({rq[0], dhcp_iface_out, dhcp_code_out, dhcp_opt_len_out, dhcp_code_known_out, dhcp_code_reserved_out}, {9'h199, 24'h01_0203, 8'h0c, 8'h01, 2'h2});
    @(posedge ref_clk_in);
    ce_in <= 1'b0;
    send('{8'h02, 8'h04, 8'hff, 8'hff, 8'hff, 8'h85}, 1'b0);
    chk({byte_ready_out, lrdp_src_inst.q.size() > 0, dhcp_opt_len_out}, {2'h1, 8'h01});
    @(posedge ref_clk_in);
    ce_in <= 1'b1;
    send(no_bytes, 1'b1);
    chk({dhcp_iface_all_out, dhcp_opt_len_out, dhcp_code_reserved_out, hdr_n[3:0]}, {1'b1, 8'h00, 1'b1, 4'h4});
  endtask
  initial begin
    arst_n_in = 1'b0;
    ce_in = 1'b1;
    msg_bcast_in = 1'b0;
    rec_ready_in = 1'b1;
    gap = 4'h0;
    repeat (3) @(posedge ref_clk_in);
    arst_n_in <= 1'b1;
    @(posedge ref_clk_in);
    t_logon();
    t_reserved();
    t_dhcp();
    t_skip();
    wrap_up();
  end
endmodule
